// ===== include/bstc_defs.vh
`ifndef BSTC_DEFS_VH
`define BSTC_DEFS_VH

// Clock and timing resolution
`define BSTC_CLK_PERIOD_NS 5
`define BSTC_RES_US 5
`define BSTC_TICK_CYC ((`BSTC_RES_US * 1000) / `BSTC_CLK_PERIOD_NS)

// Register offsets
`define BSTC_ADDR_WAIT 8'h28
`define BSTC_ADDR_ODSAMP 8'h29
`define BSTC_ADDR_CTRL 8'h30
`define BSTC_ADDR_STAT 8'h31

// Reset values
`define BSTC_RST_WAIT 8'h11
`define BSTC_RST_ODSAMP 8'h0C
`define BSTC_RST_CTRL 8'h00

// Field positions in the wait register
`define BSTC_SETTLE_MSB 7
`define BSTC_SETTLE_LSB 4
`define BSTC_DISCH_MSB 3
`define BSTC_DISCH_LSB 0

// Field positions in the overdrive and sampling register
`define BSTC_OD_MSB 5
`define BSTC_OD_LSB 4
`define BSTC_SAMP_MSB 3
`define BSTC_SAMP_LSB 2
`define BSTC_ZC_MSB 1
`define BSTC_ZC_LSB 0

// Control register: actuator type bit
`define BSTC_CTRL_ERM_BIT 0

// Resonant wait table in microseconds
`define BSTC_LRA_US_0 15
`define BSTC_LRA_US_1 25
`define BSTC_LRA_US_2 50
`define BSTC_LRA_US_3 75
`define BSTC_LRA_US_4 90
`define BSTC_LRA_US_5 105
`define BSTC_LRA_US_6 120
`define BSTC_LRA_US_7 135
`define BSTC_LRA_US_8 150
`define BSTC_LRA_US_9 165
`define BSTC_LRA_US_10 180
`define BSTC_LRA_US_11 195
`define BSTC_LRA_US_12 210
`define BSTC_LRA_US_13 235
`define BSTC_LRA_US_14 260
`define BSTC_LRA_US_15 285

// Eccentric-mass wait table in microseconds
`define BSTC_ERM_US_0 45
`define BSTC_ERM_US_1 75
`define BSTC_ERM_US_2 150
`define BSTC_ERM_US_3 225

// Amplitude sampling delay in microseconds
`define BSTC_SAMP_US_0 150
`define BSTC_SAMP_US_1 200
`define BSTC_SAMP_US_2 250
`define BSTC_SAMP_US_3 300

// Zero-crossing detection window in microseconds
`define BSTC_ZC_US_0 100
`define BSTC_ZC_US_1 200
`define BSTC_ZC_US_2 300
`define BSTC_ZC_US_3 390

// Overdrive and braking limit in milliseconds
`define BSTC_OD_MS_1 25
`define BSTC_OD_MS_2 50
`define BSTC_OD_MS_3 100

`endif

// ===== design/bstc_timer.v
`timescale 1ns/1ps
// One-shot interval timer counting whole resolution ticks
module bstc_timer #(
   parameter TICK_CYC = 1000
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire ce_in,
   input wire start_in,
   input wire stop_in,
   input wire [14:0] load_in,
   output wire busy_out,
   output wire done_out
);
   reg [15:0] pre_q; // Cycles within the current tick
   reg [14:0] cnt_q; // Ticks still to run
   reg busy_q; // Interval running
   reg done_q; // One-cycle end pulse
   wire tick_end; // Last cycle of a tick

   assign tick_end = (pre_q == TICK_CYC[15:0] - 16'h0001);
   assign busy_out = busy_q;
   assign done_out = done_q;

   // Prescaler restarts with each start, so intervals are exact
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pre_q <= 16'h0000;
         cnt_q <= 15'h0000;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else if (ce_in) begin
         done_q <= 1'b0;
         if (start_in) begin
            // Start wins over stop and restarts a running interval
            pre_q <= 16'h0000;
            cnt_q <= load_in;
            busy_q <= (load_in != 15'h0000);
            done_q <= (load_in == 15'h0000);
         end else if (stop_in) begin
            // Abandon silently
            busy_q <= 1'b0;
         end else if (busy_q) begin
            if (tick_end) begin
               pre_q <= 16'h0000;
               if (cnt_q == 15'h0001) begin
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
               end
               cnt_q <= cnt_q - 15'h0001;
            end else begin
               pre_q <= pre_q + 16'h0001;
            end
         end
      end
   end
endmodule

// ===== design/bstc_top.v
`timescale 1ns/1ps
`include "bstc_defs.vh"
module bstc_top #(
   parameter TICK_CYC = `BSTC_TICK_CYC
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire ce_in,
   input wire [7:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output wire [7:0] rdata_out,
   input wire sense_start_in,
   input wire zero_cross_in,
   input wire zc_arm_in,
   input wire od_active_in,
   input wire cal_diag_in,
   output wire coil_discharge_wait_out,
   output wire adc_hold_off_out,
   output wire adc_convert_out,
   output wire bemf_sample_out,
   output wire zc_window_out,
   output wire auto_overdrive_out,
   output wire rated_clamp_out
);
   // Number of timers and their slots
   localparam NT = 5;
   localparam T_DISCH = 0;
   localparam T_SETTLE = 1;
   localparam T_SAMP = 2;
   localparam T_ZC = 3;
   localparam T_OD = 4;

   // Software registers
   reg [7:0] wait_q; // sense_wait_times
   reg [7:0] odsamp_q; // overdrive_sample_timing
   reg [7:0] ctrl_q; // Actuator type control
   reg [7:0] rdata_q; // Read data, valid the cycle after a read
   reg [7:0] rdata_d; // Next read data

   // Overdrive tracking
   reg od_active_q; // Previous overdrive level, for edge detect
   reg clamp_q; // Output held at rated clamp
   reg [14:0] od_ticks; // Limit in ticks

   // Timer plumbing
   wire [NT-1:0] t_start; // Start strobes
   wire [NT-1:0] t_stop; // Abort strobes
   wire [NT-1:0] t_busy; // Running flags
   wire [NT-1:0] t_done; // End pulses
   wire [15*NT-1:0] t_load; // Interval lengths in ticks

   // Field views
   wire erm_sel; // Eccentric-mass actuator selected
   wire [3:0] settle_code; // Settle wait code
   wire [3:0] disch_code; // Discharge wait code
   wire [1:0] od_code; // Overdrive limit code
   wire [1:0] samp_code; // Sample delay code
   wire [1:0] zc_code; // Detection window code
   wire limit_on; // Time clamp in force
   wire od_rise; // Overdrive or braking began

   assign erm_sel = ctrl_q[`BSTC_CTRL_ERM_BIT];
   assign settle_code = wait_q[`BSTC_SETTLE_MSB:`BSTC_SETTLE_LSB];
   assign disch_code = wait_q[`BSTC_DISCH_MSB:`BSTC_DISCH_LSB];
   assign od_code = odsamp_q[`BSTC_OD_MSB:`BSTC_OD_LSB];
   assign samp_code = odsamp_q[`BSTC_SAMP_MSB:`BSTC_SAMP_LSB];
   assign zc_code = odsamp_q[`BSTC_ZC_MSB:`BSTC_ZC_LSB];

   // Microseconds to ticks of the timer resolution
   function [14:0] us_to_ticks;
      input integer us;
      integer t;
      begin
         t = us / `BSTC_RES_US;
         us_to_ticks = t[14:0];
      end
   endfunction

   // Shared wait table for settle and discharge fields
   function [14:0] wait_ticks;
      input [3:0] code;
      input erm;
      integer us;
      begin
         us = `BSTC_LRA_US_0;
         if (erm) begin
            // Eccentric codes above 3 are undefined; saturate at code 3
            case (code)
               4'h0: us = `BSTC_ERM_US_0;
               4'h1: us = `BSTC_ERM_US_1;
               4'h2: us = `BSTC_ERM_US_2;
               default: us = `BSTC_ERM_US_3;
            endcase
         end else begin
            case (code)
               4'h0: us = `BSTC_LRA_US_0;
               4'h1: us = `BSTC_LRA_US_1;
               4'h2: us = `BSTC_LRA_US_2;
               4'h3: us = `BSTC_LRA_US_3;
               4'h4: us = `BSTC_LRA_US_4;
               4'h5: us = `BSTC_LRA_US_5;
               4'h6: us = `BSTC_LRA_US_6;
               4'h7: us = `BSTC_LRA_US_7;
               4'h8: us = `BSTC_LRA_US_8;
               4'h9: us = `BSTC_LRA_US_9;
               4'hA: us = `BSTC_LRA_US_10;
               4'hB: us = `BSTC_LRA_US_11;
               4'hC: us = `BSTC_LRA_US_12;
               4'hD: us = `BSTC_LRA_US_13;
               4'hE: us = `BSTC_LRA_US_14;
               default: us = `BSTC_LRA_US_15;
            endcase
         end
         wait_ticks = us_to_ticks(us);
      end
   endfunction

   // Amplitude sampling delay table
   function [14:0] samp_ticks;
      input [1:0] code;
      integer us;
      begin
         us = `BSTC_SAMP_US_0;
         case (code)
            2'h0: us = `BSTC_SAMP_US_0;
            2'h1: us = `BSTC_SAMP_US_1;
            2'h2: us = `BSTC_SAMP_US_2;
            default: us = `BSTC_SAMP_US_3;
         endcase
         samp_ticks = us_to_ticks(us);
      end
   endfunction

   // Zero-crossing detection window table
   function [14:0] zc_ticks;
      input [1:0] code;
      integer us;
      begin
         us = `BSTC_ZC_US_0;
         case (code)
            2'h0: us = `BSTC_ZC_US_0;
            2'h1: us = `BSTC_ZC_US_1;
            2'h2: us = `BSTC_ZC_US_2;
            default: us = `BSTC_ZC_US_3;
         endcase
         zc_ticks = us_to_ticks(us);
      end
   endfunction

   // Overdrive limit in ticks; code 0 leaves the clamp off
   always @* begin
      case (od_code)
         2'h1: od_ticks = us_to_ticks(`BSTC_OD_MS_1 * 1000);
         2'h2: od_ticks = us_to_ticks(`BSTC_OD_MS_2 * 1000);
         2'h3: od_ticks = us_to_ticks(`BSTC_OD_MS_3 * 1000);
         default: od_ticks = 15'h0000;
      endcase
   end

   // Limit applies only outside calibration and diagnostics
   assign limit_on = (od_code != 2'h0) && !cal_diag_in;
   assign od_rise = od_active_in && !od_active_q;

   // Timer loads
   assign t_load[15*T_DISCH +: 15] = wait_ticks(disch_code, erm_sel);
   assign t_load[15*T_SETTLE +: 15] = wait_ticks(settle_code, erm_sel);
   assign t_load[15*T_SAMP +: 15] = samp_ticks(samp_code);
   assign t_load[15*T_ZC +: 15] = zc_ticks(zc_code);
   assign t_load[15*T_OD +: 15] = od_ticks;

   // Sense sequence: discharge, then settle, then convert
   assign t_start[T_DISCH] = sense_start_in;
   assign t_start[T_SETTLE] = t_done[T_DISCH];
   assign t_start[T_SAMP] = zero_cross_in;
   assign t_start[T_ZC] = zc_arm_in;
   assign t_start[T_OD] = od_rise && limit_on;
   assign t_stop[T_DISCH] = 1'b0;
   assign t_stop[T_SETTLE] = 1'b0;
   assign t_stop[T_SAMP] = 1'b0;
   assign t_stop[T_ZC] = 1'b0;
   // Overdrive timer ends with the phase or when the limit is lifted
   assign t_stop[T_OD] = !od_active_in || !limit_on;

   // One interval timer per timed function
   genvar gi;
   generate
      for (gi = 0; gi < NT; gi = gi + 1) begin : g_tmr
         bstc_timer #(
            .TICK_CYC(TICK_CYC)
         ) u_tmr (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .ce_in(ce_in),
            .start_in(t_start[gi]),
            .stop_in(t_stop[gi]),
            .load_in(t_load[15*gi +: 15]),
            .busy_out(t_busy[gi]),
            .done_out(t_done[gi])
         );
      end
   endgenerate

   // Register writes
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wait_q <= `BSTC_RST_WAIT;
         odsamp_q <= `BSTC_RST_ODSAMP;
         ctrl_q <= `BSTC_RST_CTRL;
      end else if (ce_in && wr_in) begin
         case (addr_in)
            `BSTC_ADDR_WAIT: wait_q <= wdata_in;
            `BSTC_ADDR_ODSAMP: odsamp_q <= wdata_in;
            `BSTC_ADDR_CTRL: ctrl_q <= {7'h00, wdata_in[`BSTC_CTRL_ERM_BIT]};
            default: ctrl_q <= ctrl_q;
         endcase
      end
   end

   // Read mux; unmapped addresses read zero
   always @* begin
      case (addr_in)
         `BSTC_ADDR_WAIT: rdata_d = wait_q;
         `BSTC_ADDR_ODSAMP: rdata_d = odsamp_q;
         `BSTC_ADDR_CTRL: rdata_d = ctrl_q;
         `BSTC_ADDR_STAT: rdata_d = {2'h0, clamp_q, t_busy};
         default: rdata_d = 8'h00;
      endcase
   end

   // Read data register, stands only in the cycle after the strobe
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_q <= 8'h00;
      end else if (ce_in) begin
         if (rd_in) begin
            rdata_q <= rdata_d;
         end else begin
            rdata_q <= 8'h00;
         end
      end
   end

   // Overdrive clamp: set when the limit expires mid-phase
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         od_active_q <= 1'b0;
         clamp_q <= 1'b0;
      end else if (ce_in) begin
         od_active_q <= od_active_in;
         if (!od_active_in || !limit_on) begin
            // Phase over, or calibration took over
            clamp_q <= 1'b0;
         end else if (t_done[T_OD]) begin
            // May land away from a zero crossing
            clamp_q <= 1'b1;
         end
      end
   end

   // Outputs
   assign rdata_out = rdata_q;
   assign coil_discharge_wait_out = t_busy[T_DISCH];
   // Done pulse bridges the hand-over cycle between discharge and settle
   assign adc_hold_off_out = t_busy[T_DISCH] | t_done[T_DISCH] | t_busy[T_SETTLE];
   assign adc_convert_out = t_done[T_SETTLE];
   assign bemf_sample_out = t_done[T_SAMP];
   assign zc_window_out = t_busy[T_ZC];
   assign auto_overdrive_out = !limit_on;
   assign rated_clamp_out = clamp_q;
endmodule

// ===== bench/bstc_top_chk.sv
`timescale 1ns/1ps
// Timing checks on the top module's ports
module bstc_top_chk #(
   parameter TICK_CYC = 1000
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire ce_in,
   input wire sense_start_in,
   input wire zero_cross_in,
   input wire zc_arm_in,
   input wire od_active_in,
   input wire cal_diag_in,
   input wire coil_discharge_wait_out,
   input wire adc_hold_off_out,
   input wire adc_convert_out,
   input wire bemf_sample_out,
   input wire zc_window_out,
   input wire auto_overdrive_out,
   input wire rated_clamp_out
);
   // One clock domain, one reset
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Shortest window is far beyond eight cycles
   sequence win_open_s; zc_window_out [*8]; endsequence
   // No sample pulse early after a crossing
   sequence samp_quiet_s; !bemf_sample_out [*8]; endsequence
   // No clamp in the first cycles of a phase
   sequence clamp_quiet_s; !rated_clamp_out [*8]; endsequence
   conv_after_hold_a: assert property (adc_convert_out |-> $past(adc_hold_off_out))
      else $error("convert without hold-off");
   conv_pulse_a: assert property (adc_convert_out |=> !adc_convert_out)
      else $error("convert longer than one cycle");
   hold_no_gap_a: assert property ($fell(coil_discharge_wait_out) |-> adc_hold_off_out)
      else $error("hold-off gap after discharge");
   disch_in_hold_a: assert property (coil_discharge_wait_out |-> adc_hold_off_out)
      else $error("discharge outside hold-off");
   start_waits_a: assert property (sense_start_in && ce_in |=>
      coil_discharge_wait_out && adc_hold_off_out) else $error("sense start ignored");
   window_open_a: assert property (zc_arm_in && ce_in |=> win_open_s)
      else $error("window closed early");
   sample_delay_a: assert property (zero_cross_in && ce_in |=> samp_quiet_s)
      else $error("sample too soon");
   clamp_delay_a: assert property ($rose(od_active_in) |-> ##2 clamp_quiet_s)
      else $error("clamp too soon");
   clamp_cause_a: assert property (rated_clamp_out |->
      $past(od_active_in) && !$past(cal_diag_in)) else $error("clamp without phase");
   cal_auto_od_a: assert property (cal_diag_in |-> auto_overdrive_out)
      else $error("limit applied in calibration");
endmodule

bind bstc_top bstc_top_chk #(.TICK_CYC(TICK_CYC)) i_bstc_top_chk (
   .clk_in, .rst_n_in, .ce_in, .sense_start_in, .zero_cross_in, .zc_arm_in,
   .od_active_in, .cal_diag_in, .coil_discharge_wait_out, .adc_hold_off_out,
   .adc_convert_out, .bemf_sample_out, .zc_window_out, .auto_overdrive_out,
   .rated_clamp_out);

// ===== bench/bstc_actuator_model.sv
`timescale 1ns/1ps
// Actuator: crossings every PER cycles, overdrive phase of ODC cycles
module bstc_actuator_model #(
   parameter int PER = 200,
   parameter int ODC = 12000
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic run_in,
   output logic zero_cross_out,
   output logic od_active_out
);
   int cnt_q; // Cycles since run began
   // Restarts whenever run drops
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= 0;
         zero_cross_out <= 1'b0;
         od_active_out <= 1'b0;
      end else begin
         cnt_q <= run_in ? cnt_q + 1 : 0;
         zero_cross_out <= run_in && (cnt_q % PER == PER - 1);
         od_active_out <= run_in && (cnt_q < ODC);
      end
   end
endmodule

// ===== bench/bstc_top_tb.sv
`timescale 1ns/1ps
module bstc_top_tb;
   localparam int T = 2; // Cycles per tick
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic ce_in = 1'b1;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic sense_start_in = 1'b0;
   logic zc_arm_in = 1'b0;
   logic cal_diag_in = 1'b0;
   logic run = 1'b0;
   wire [7:0] rdata_out;
   wire zero_cross_in, od_active_in, coil_discharge_wait_out, adc_hold_off_out;
   wire adc_convert_out, bemf_sample_out, zc_window_out, auto_overdrive_out;
   wire rated_clamp_out;
   wire [3:0] obs = {~zc_window_out, rated_clamp_out, bemf_sample_out, adc_convert_out};
   int failures = 0;
   int cmp_count = 0;
   int n;
   // Wait, sample delay and window tables in microseconds
   int lra[16] = '{15, 25, 50, 75, 90, 105, 120, 135, 150, 165, 180, 195, 210, 235, 260, 285};
   int erm[4] = '{45, 75, 150, 225};
   int sd[4] = '{150, 200, 250, 300};
   int zw[4] = '{100, 200, 300, 390};

   always #2.5 clk_in = ~clk_in; // 200 MHz

   bstc_top #(.TICK_CYC(T)) i_bstc_top (.clk_in, .rst_n_in, .ce_in, .addr_in, .wdata_in,
      .wr_in, .rd_in, .rdata_out, .sense_start_in, .zero_cross_in, .zc_arm_in,
      .od_active_in, .cal_diag_in, .coil_discharge_wait_out, .adc_hold_off_out,
      .adc_convert_out, .bemf_sample_out, .zc_window_out, .auto_overdrive_out,
      .rated_clamp_out);
   bstc_actuator_model i_bstc_actuator_model (.clk_in, .rst_n_in, .run_in(run),
      .zero_cross_out(zero_cross_in), .od_active_out(od_active_in));

   // Compare and count
   task chk(input [15:0] s, input [15:0] e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // One-cycle register write
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clk_in);
      addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   // Read, data checked the cycle after
   task rd(input [7:0] a, input [7:0] e);
      @(posedge clk_in);
      addr_in <= a; rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, e);
   endtask
   // Cycles from the launching edge until an observed bit is high
   task automatic cnt(input int b, output int k);
      k = 0;
      do begin
         @(posedge clk_in);
         sense_start_in <= 1'b0;
         zc_arm_in <= 1'b0;
         #1 k++;
      end while (obs[b] !== 1'b1 && k < 50000);
   endtask
   // Wait until the model raises a signal
   task wait_model(input int sel);
      do begin @(posedge clk_in); #1; end
      while ((sel ? od_active_in : zero_cross_in) !== 1'b1);
   endtask
   // Reset values, readback, unmapped place
   task t_regs;
      rd(8'h28, 8'h11);
      rd(8'h29, 8'h0C);
      chk(auto_overdrive_out, 1'b1);
      rd(8'h40, 8'h00);
      wr(8'h29, 8'hC5);
      rd(8'h29, 8'hC5);
   endtask
   // Discharge then settle, every code, both actuator types
   task t_sense;
      for (int c = 0; c < 20; c++) begin
         if (c == 16) wr(8'h30, 8'h01); // Eccentric-mass table
         wr(8'h28, c < 16 ? {c[3:0], ~c[3:0]} : {2'h0, ~c[1:0], 2'h0, c[1:0]});
         @(posedge clk_in);
         sense_start_in <= 1'b1;
         cnt(0, n);
         chk(n, c < 16 ? (lra[c] + lra[15 - c]) / 5 * T + 2 :
            (erm[c - 16] + erm[19 - c]) / 5 * T + 2);
      end
      wr(8'h30, 8'h00);
   endtask
   // Detection window length, every code
   task t_window;
      for (int c = 0; c < 4; c++) begin
         wr(8'h29, {6'h0, c[1:0]});
         @(posedge clk_in);
         zc_arm_in <= 1'b1;
         cnt(3, n);
         chk(n, zw[c] / 5 * T + 1);
      end
   endtask
   // Clock enable low freezes a running window
   task t_freeze;
      wr(8'h29, 8'h00);
      @(posedge clk_in);
      zc_arm_in <= 1'b1;
      @(posedge clk_in);
      zc_arm_in <= 1'b0;
      ce_in <= 1'b0;
      repeat (zw[0] / 5 * T) @(posedge clk_in);
      ce_in <= 1'b1;
      #1 chk(zc_window_out, 1'b1);
      cnt(3, n);
      chk(n, zw[0] / 5 * T);
   endtask
   // Sample delay after real crossings, every code
   task t_sample;
      run <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr(8'h29, {4'h0, c[1:0], 2'h0});
         wait_model(0);
         cnt(1, n);
         chk(n, sd[c] / 5 * T + 1);
      end
      run <= 1'b0;
   endtask
   // Overdrive clamp at 25 ms, then calibration overrides it
   task t_clamp;
      wr(8'h29, 8'h10);
      #1 chk(auto_overdrive_out, 1'b0);
      run <= 1'b1;
      wait_model(1);
      cnt(2, n);
      chk(n, 25000 / 5 * T + 2);
      @(posedge clk_in);
      cal_diag_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      #1 chk(rated_clamp_out, 1'b0);
      chk(auto_overdrive_out, 1'b1);
      @(posedge clk_in);
      run <= 1'b0;
      cal_diag_in <= 1'b0;
   endtask
   // Verdict and end of run
   task stop_test;
      if (failures == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_regs;
      t_sense;
      t_window;
      t_freeze;
      t_sample;
      t_clamp;
      stop_test;
   end
   // Hang guard, well past the expected run
   initial begin
      #200000;
      failures++;
      stop_test;
   end
endmodule
